/* verilog/rgb_pixel_receiver.sv */
// Parallel RGB pixel receiver with DE and HV modes, line buffer and Avalon registers
`timescale 1ns/1ps
module rgb_pixel_receiver
	import rgb_rx_pkg::*;
#(
	parameter int H_ACT = 480,
	parameter int V_ACT = 480,
	parameter int LB_AW = 9
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_nrst,
	input  wire logic [AVS_AW-1:0]    i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [AVS_DW-1:0]    i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic      [AVS_DW-1:0]    o_avs_readdata,
	output logic                      o_avs_waitrequest,
	input  wire logic                 i_cmd_sel_n,
	input  wire logic                 i_dot_clock_pin,
	input  wire logic                 i_line_sync_n,
	input  wire logic                 i_frame_sync_n,
	input  wire logic                 i_pixel_valid,
	input  wire logic [PIX_W-1:0]     i_pixel_bus,
	output logic      [PIX_W-1:0]     o_pixel_rgb,
	output logic      [COORD_W-1:0]   o_pixel_x,
	output logic      [COORD_W-1:0]   o_pixel_y,
	output logic                      o_pixel_stb,
	output logic                      o_frame_start
);

	localparam int PIN_W = PIX_W + 5;

	// Byte-lane merge for Avalon writes
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Colour lane mapping onto RGB888, narrow colours widened by MSB repeat
	function automatic logic [PIX_W-1:0] map_pixel(input logic [PIX_W-1:0] bus,
		input logic [3:0] fmt, input logic packed18);
		logic [5:0] r6;
		logic [5:0] g6;
		logic [5:0] b6;
		logic [PIX_W-1:0] res;
		r6 = packed18 ? bus[17:12] : bus[21:16];
		g6 = packed18 ? bus[11:6] : bus[13:8];
		b6 = bus[5:0];
		case (fmt)
			FMT_16: begin
				res = {bus[20:16], bus[20:18], bus[13:8], bus[13:12],
					bus[4:0], bus[4:2]};
			end
			FMT_18: begin
				res = {r6, r6[5:4], g6, g6[5:4], b6, b6[5:4]};
			end
			default: begin
				res = bus;
			end
		endcase
		return res;
	endfunction

	// Pin synchroniser: two flops on every pin from the link or command side
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	wire  [PIN_W-1:0] pin_raw = {i_cmd_sel_n, i_dot_clock_pin, i_line_sync_n,
		i_frame_sync_n, i_pixel_valid, i_pixel_bus};

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			pin_s1_r <= '1;
			pin_s2_r <= '1;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	wire             cmd_sel_n_s = pin_s2_r[PIX_W+4];
	wire             dot_s       = pin_s2_r[PIX_W+3];
	wire             hs_n_s      = pin_s2_r[PIX_W+2];
	wire             vs_n_s      = pin_s2_r[PIX_W+1];
	wire             de_s        = pin_s2_r[PIX_W];
	wire [PIX_W-1:0] bus_s       = pin_s2_r[PIX_W-1:0];

	// Register file, one aligned word each
	logic [31:0] reg_r [NREG_RW];
	logic [15:0] frame_cnt_r;

	wire             hv_mode  = reg_r[REG_CTRL][CTRL_HV_BIT];
	wire             packed18 = reg_r[REG_CTRL][CTRL_PACK_BIT];
	wire [3:0]       fmt      = reg_r[REG_CTRL][CTRL_FMT_LSB +: 4];
	wire             cap_en   = reg_r[REG_CTRL][CTRL_EN_BIT];
	wire [7:0]       hbp      = reg_r[REG_PORCH][PORCH_HBP_LSB +: 8];
	wire [7:0]       vbp      = reg_r[REG_PORCH][PORCH_VBP_LSB +: 8];
	wire [COORD_W-1:0] win_x0 = reg_r[REG_WIN_X][WIN_LO_LSB +: COORD_W];
	wire [COORD_W-1:0] win_x1 = reg_r[REG_WIN_X][WIN_HI_LSB +: COORD_W];
	wire [COORD_W-1:0] win_y0 = reg_r[REG_WIN_Y][WIN_LO_LSB +: COORD_W];
	wire [COORD_W-1:0] win_y1 = reg_r[REG_WIN_Y][WIN_HI_LSB +: COORD_W];

	// Dot clock edge and sync leading edges, all judged at dot rise
	logic dot_prev_r;
	logic hs_prev_r;
	logic vs_prev_r;
	logic de_prev_r;

	wire dot_rise   = dot_s & ~dot_prev_r;
	wire line_lead  = dot_rise & hs_prev_r & ~hs_n_s;
	wire frame_lead = dot_rise & vs_prev_r & ~vs_n_s;
	wire de_fall    = dot_rise & de_prev_r & ~de_s;

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			dot_prev_r <= 1'b1;
			hs_prev_r  <= 1'b1;
			vs_prev_r  <= 1'b1;
			de_prev_r  <= 1'b0;
		end else begin
			dot_prev_r <= dot_s;
			if (dot_rise) begin
				hs_prev_r <= hs_n_s;
				vs_prev_r <= vs_n_s;
				de_prev_r <= de_s;
			end
		end
	end

	// Horizontal walk for HV mode: sync lead, back porch, active run, idle
	h_state_t        h_st_r;
	h_state_t        h_st_nxt;
	logic [8:0]      hcnt_r;
	logic [COORD_W-1:0] x_r;

	wire [8:0] hcnt_inc  = hcnt_r + 9'h001;
	wire       porch_end = (hcnt_inc == {1'b0, hbp});
	wire       row_end   = (x_r == COORD_W'(H_ACT - 1));

	always_comb begin
		h_st_nxt = h_st_r;
		case (h_st_r)
			H_SYNC: begin
				h_st_nxt = H_SYNC;
			end
			H_PORCH: begin
				if (porch_end) begin
					h_st_nxt = H_ACTIVE;
				end
			end
			H_ACTIVE: begin
				if (row_end) begin
					h_st_nxt = H_DONE;
				end
			end
			default: begin
				h_st_nxt = H_DONE;
			end
		endcase
		if (line_lead) begin
			h_st_nxt = H_PORCH;
		end
		if (!hv_mode) begin
			h_st_nxt = H_SYNC;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			h_st_r <= H_SYNC;
			hcnt_r <= '0;
		end else if (dot_rise) begin
			h_st_r <= h_st_nxt;
			hcnt_r <= line_lead ? 9'h000 : hcnt_inc;
		end
	end

	// Column counter: HV counts active run, DE counts valid pixels
	wire x_room = (x_r < COORD_W'(H_ACT));
	wire x_clr  = hv_mode ? line_lead : (de_fall | line_lead);
	wire x_step = hv_mode ? (h_st_r == H_ACTIVE) : (de_s & x_room);
	wire [COORD_W-1:0] x_nxt = x_clr ? '0 : (x_step ? x_r + 1'b1 : x_r);

	// Line counter: HV counts sync lines from frame lead, DE counts valid runs
	logic [LINE_W-1:0] line_r;
	wire line_step = hv_mode ? line_lead : de_fall;
	wire line_room = (line_r != '1);
	wire [LINE_W-1:0] line_nxt = frame_lead ? '0 :
		((line_step & line_room) ? line_r + 1'b1 : line_r);

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			x_r    <= '0;
			line_r <= '0;
		end else if (dot_rise) begin
			x_r    <= x_nxt;
			line_r <= line_nxt;
		end
	end

	// Active line decision; the frame runs on until the host's next frame sync
	wire [LINE_W-1:0] vbp_w     = LINE_W'(vbp);
	wire [LINE_W-1:0] vact_end  = vbp_w + LINE_W'(V_ACT);
	wire              hv_line   = (line_r >= vbp_w) && (line_r < vact_end);
	wire              de_line   = (line_r < LINE_W'(V_ACT));
	wire              line_act  = hv_mode ? hv_line : de_line;
	wire [LINE_W-1:0] y_full    = hv_mode ? (line_r - vbp_w) : line_r;
	wire [COORD_W-1:0] y_now    = y_full[COORD_W-1:0];

	// Pixel acceptance, gated by the window address area
	wire pix_hit = hv_mode ? (h_st_r == H_ACTIVE) : (de_s & x_room);
	wire in_win  = (x_r >= win_x0) && (x_r <= win_x1) &&
		(y_now >= win_y0) && (y_now <= win_y1);
	wire pix_take = dot_rise & cap_en & line_act & pix_hit;
	wire pix_wr   = pix_take & in_win;
	wire [PIX_W-1:0] pix_rgb = map_pixel(bus_s, fmt, packed18);

	// Line buffer holding the most recent line
	lbuf_if #(.DW(PIX_W), .AW(LB_AW)) lb ();

	assign lb.we    = pix_wr;
	assign lb.waddr = x_r[LB_AW-1:0];
	assign lb.wdata = pix_rgb;
	assign lb.raddr = reg_r[REG_LB_ADDR][LB_AW-1:0];

	line_buffer_mem #(
		.DEPTH (1 << LB_AW),
		.DW    (PIX_W),
		.AW    (LB_AW)
	) u_lbuf (
		.i_clk_sys (i_clk_sys),
		.lb        (lb)
	);

	// Pixel stream and frame marker outputs
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_pixel_stb   <= 1'b0;
			o_pixel_rgb   <= '0;
			o_pixel_x     <= '0;
			o_pixel_y     <= '0;
			o_frame_start <= 1'b0;
		end else begin
			o_pixel_stb   <= pix_wr;
			o_frame_start <= frame_lead;
			if (pix_wr) begin
				o_pixel_rgb <= pix_rgb;
				o_pixel_x   <= x_r;
				o_pixel_y   <= y_now;
			end
		end
	end

	// Frame counter for status
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			frame_cnt_r <= '0;
		end else if (frame_lead) begin
			frame_cnt_r <= frame_cnt_r + 16'h0001;
		end
	end

	// Avalon handshake: request seen with waitrequest high, answer one cycle later, two cycles for line buffer data reads
	wire bus_req  = i_avs_read | i_avs_write;
	wire sel_ok   = ~cmd_sel_n_s;
	wire lb_rd    = i_avs_read & (i_avs_address == OFS_LB_DATA);
	logic lb_wait_r;
	wire ans_load = bus_req & o_avs_waitrequest & (~lb_rd | lb_wait_r);
	wire commit   = bus_req & ~o_avs_waitrequest;
	wire wr_ok    = commit & i_avs_write & sel_ok;

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_avs_waitrequest <= 1'b1;
			lb_wait_r         <= 1'b0;
		end else begin
			o_avs_waitrequest <= ~(o_avs_waitrequest & ans_load);
			lb_wait_r <= bus_req & o_avs_waitrequest & lb_rd & ~lb_wait_r;
		end
	end

	// Writable registers, one per offset, written at the edge that ends the answer cycle
	for (genvar gi = 0; gi < NREG_RW; gi++) begin : g_reg
		wire hit = wr_ok & (i_avs_address == RW_OFS[gi]);
		always_ff @(posedge i_clk_sys) begin
			if (!i_nrst) begin
				reg_r[gi] <= RW_RST[gi];
			end else if (hit) begin
				reg_r[gi] <= be_merge(reg_r[gi], i_avs_writedata,
					i_avs_byteenable) & RW_MASK[gi];
			end
		end
	end

	// Read decode; unmapped or deselected reads answer zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (!sel_ok) begin
			rd_mux = 32'h0000_0000;
		end else if (i_avs_address == OFS_CTRL) begin
			rd_mux = reg_r[REG_CTRL];
		end else if (i_avs_address == OFS_PORCH) begin
			rd_mux = reg_r[REG_PORCH];
		end else if (i_avs_address == OFS_WIN_X) begin
			rd_mux = reg_r[REG_WIN_X];
		end else if (i_avs_address == OFS_WIN_Y) begin
			rd_mux = reg_r[REG_WIN_Y];
		end else if (i_avs_address == OFS_STATUS) begin
			rd_mux[STAT_LINE_LSB +: LINE_W] = line_r;
			rd_mux[STAT_FRM_LSB +: 16]      = frame_cnt_r;
		end else if (i_avs_address == OFS_LB_ADDR) begin
			rd_mux = reg_r[REG_LB_ADDR];
		end else if (i_avs_address == OFS_LB_DATA) begin
			rd_mux[PIX_W-1:0] = lb.rdata;
		end
	end

	// Read data register, stands through the answer cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_avs_readdata <= '0;
		end else if (ans_load & i_avs_read) begin
			o_avs_readdata <= rd_mux;
		end
	end

endmodule

/* verilog/rgb_rx_pkg.sv */
// Constants, register map and types for the RGB pixel receiver
package rgb_rx_pkg;

	// Avalon register window, byte offsets
	localparam int          AVS_AW      = 5;
	localparam int          AVS_DW      = 32;
	localparam logic [4:0]  OFS_CTRL    = 5'h00;
	localparam logic [4:0]  OFS_PORCH   = 5'h04;
	localparam logic [4:0]  OFS_WIN_X   = 5'h08;
	localparam logic [4:0]  OFS_WIN_Y   = 5'h0C;
	localparam logic [4:0]  OFS_STATUS  = 5'h10;
	localparam logic [4:0]  OFS_LB_ADDR = 5'h14;
	localparam logic [4:0]  OFS_LB_DATA = 5'h18;

	// Writable registers, indexed in the order of the tables below
	localparam int NREG_RW     = 5;
	localparam int REG_CTRL    = 0;
	localparam int REG_PORCH   = 1;
	localparam int REG_WIN_X   = 2;
	localparam int REG_WIN_Y   = 3;
	localparam int REG_LB_ADDR = 4;
	localparam logic [4:0]  RW_OFS [NREG_RW] = '{OFS_CTRL, OFS_PORCH, OFS_WIN_X,
		OFS_WIN_Y, OFS_LB_ADDR};
	localparam logic [31:0] RW_MASK [NREG_RW] = '{32'h0000_01F3, 32'h0000_FFFF,
		32'h03FF_03FF, 32'h03FF_03FF, 32'h0000_01FF};
	localparam logic [31:0] RW_RST [NREG_RW] = '{32'h0000_0170, 32'h0000_0202,
		32'h01DF_0000, 32'h01DF_0000, 32'h0000_0000};

	// Control word fields
	localparam int CTRL_HV_BIT   = 0;
	localparam int CTRL_PACK_BIT = 1;
	localparam int CTRL_FMT_LSB  = 4;
	localparam int CTRL_EN_BIT   = 8;
	// Porch word fields
	localparam int PORCH_HBP_LSB = 0;
	localparam int PORCH_VBP_LSB = 8;
	// Window words: start in low half, end in high half
	localparam int WIN_LO_LSB    = 0;
	localparam int WIN_HI_LSB    = 16;
	// Status word fields
	localparam int STAT_LINE_LSB = 0;
	localparam int STAT_FRM_LSB  = 16;

	// Pixel format codes
	localparam logic [3:0] FMT_16 = 4'h5;
	localparam logic [3:0] FMT_18 = 4'h6;
	localparam logic [3:0] FMT_24 = 4'h7;

	// Geometry and link widths
	localparam int COORD_W   = 10;
	localparam int LINE_W    = 11;
	localparam int PIX_W     = 24;
	localparam int SYNC_LEN  = 2;

	// Horizontal walk in HV mode, Gray coded
	typedef enum logic [1:0] {
		H_SYNC   = 2'b00,
		H_PORCH  = 2'b01,
		H_ACTIVE = 2'b11,
		H_DONE   = 2'b10
	} h_state_t;

endpackage

/* verilog/lbuf_if.sv */
// Port bundle between the receiver and its line buffer memory
`timescale 1ns/1ps
interface lbuf_if #(
	parameter int DW = 24,
	parameter int AW = 9
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport writer (output we, waddr, wdata, raddr, input rdata);
	modport mem    (input we, waddr, wdata, raddr, output rdata);
endinterface

/* verilog/line_buffer_mem.sv */
// One-line pixel store with registered read port
`timescale 1ns/1ps
module line_buffer_mem #(
	parameter int DEPTH = 512,
	parameter int DW    = 24,
	parameter int AW    = 9
) (
	input  wire logic i_clk_sys,
	lbuf_if.mem       lb
);
	logic [DW-1:0] store_r [DEPTH];

	// Write port, one pixel per cycle
	always_ff @(posedge i_clk_sys) begin
		if (lb.we) begin
			store_r[lb.waddr] <= lb.wdata;
		end
	end

	// Read data always comes out of a register
	always_ff @(posedge i_clk_sys) begin
		lb.rdata <= store_r[lb.raddr];
	end
endmodule

/* bench/rgb_rx_properties.sv */
// Port-level assertions for the RGB pixel receiver
`timescale 1ns/1ps
module rgb_rx_properties
	import rgb_rx_pkg::*;
#(
	parameter int H_ACT = 480
) (
	input wire logic               i_clk_sys,
	input wire logic               i_nrst,
	input wire logic               i_avs_read,
	input wire logic               i_avs_write,
	input wire logic [AVS_DW-1:0]  o_avs_readdata,
	input wire logic               o_avs_waitrequest,
	input wire logic               i_cmd_sel_n,
	input wire logic               i_dot_clock_pin,
	input wire logic               i_frame_sync_n,
	input wire logic [COORD_W-1:0] o_pixel_x,
	input wire logic               o_pixel_stb,
	input wire logic               o_frame_start
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);

	// Steps of a bus access
	sequence s_req;
		i_avs_read || i_avs_write;
	endsequence
	sequence s_rd_ack;
		i_avs_read && !o_avs_waitrequest;
	endsequence

	// Reset, bus handshake and deselected reads
	AST_RST_OUT: assert property (
		$rose(i_nrst) |-> o_avs_waitrequest && !o_pixel_stb && !o_frame_start)
		else $error("outputs not idle after reset");
	AST_ACK_ONE: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest) else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (
		$fell(o_avs_waitrequest) |-> s_req) else $error("ack without request");
	AST_ACK_BOUND: assert property (
		s_req ##0 o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest)
		else $error("request not answered");
	AST_SEL_READ0: assert property (
		i_cmd_sel_n [*6] ##0 s_rd_ack |-> o_avs_readdata == '0)
		else $error("deselected read returned data");

	// Pixel and frame strobes
	AST_STB_ONE: assert property (
		o_pixel_stb |=> !o_pixel_stb) else $error("pixel strobe too long");
	AST_STB_DOT: assert property (
		o_pixel_stb |-> $past(i_dot_clock_pin, 2)) else $error("pixel without dot rise");
	AST_X_RANGE: assert property (
		o_pixel_stb |-> o_pixel_x < H_ACT) else $error("pixel column out of range");
	AST_FS_CAUSE: assert property (
		o_frame_start |-> !$past(i_frame_sync_n, 3)) else $error("frame start without sync");
	AST_FS_ONE: assert property (
		o_frame_start |=> !o_frame_start [*8]) else $error("frame start repeated");
endmodule

bind rgb_pixel_receiver rgb_rx_properties #(.H_ACT(H_ACT)) u_props (
	.i_clk_sys, .i_nrst, .i_avs_read, .i_avs_write, .o_avs_readdata,
	.o_avs_waitrequest, .i_cmd_sel_n, .i_dot_clock_pin, .i_frame_sync_n,
	.o_pixel_x, .o_pixel_stb, .o_frame_start
);

/* bench/rgb_host_model.sv */
// Host display controller model driving dot clock, syncs and pixel bus
`timescale 1ns/1ps
module rgb_host_model
	import rgb_rx_pkg::*;
(
	output logic             o_dot_clock,
	output logic             o_line_sync_n,
	output logic             o_frame_sync_n,
	output logic             o_pixel_valid,
	output logic [PIX_W-1:0] o_pixel_bus
);
	// Free-running dot clock, phase unrelated to the system clock
	initial begin
		o_dot_clock = 1'b0;
		o_line_sync_n = 1'b1;
		o_frame_sync_n = 1'b1;
		o_pixel_valid = 1'b0;
		o_pixel_bus = 24'h000000;
		#7;
		forever #80 o_dot_clock = ~o_dot_clock;
	end

	// One line: two-clock sync, two-clock porch, pixels, three-clock front porch
	task automatic send_line(input logic fs, input int npix, input logic de,
		input logic [PIX_W-1:0] d0);
		for (int k = 0; k < npix + 7; k++) begin
			@(negedge o_dot_clock);
			o_line_sync_n <= (k >= SYNC_LEN);
			if (k == 0)
				o_frame_sync_n <= !fs;
			o_pixel_valid <= de ? (k >= 4 && k < npix + 4) : k[1];
			o_pixel_bus <= d0 + PIX_W'(k);
		end
	endtask
endmodule

/* bench/rgb_pixel_receiver_tb.sv */
// Self-checking bench for the RGB pixel receiver
`timescale 1ns/1ps
module rgb_pixel_receiver_tb
	import rgb_rx_pkg::*;
;
	logic               clk = 1'b0;
	logic               nrst, rd, wr, sel_n, waitreq, stb, fs_pulse;
	logic               dot, hs_n, vs_n, pv;
	logic [AVS_AW-1:0]  addr;
	logic [AVS_DW-1:0]  wdata, rdata;
	logic [3:0]         byteen;
	logic [PIX_W-1:0]   pbus, rgb;
	logic [COORD_W-1:0] px, py;
	logic [PIX_W-1:0]   q_rgb[$];
	logic [COORD_W-1:0] q_x[$], q_y[$];
	int                 n_errors = 0;
	int                 tests_run = 0;
	int                 n_fs = 0;

	always #10 clk = ~clk;

	rgb_pixel_receiver u_dut (
		.i_clk_sys(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(byteen),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_cmd_sel_n(sel_n),
		.i_dot_clock_pin(dot), .i_line_sync_n(hs_n), .i_frame_sync_n(vs_n),
		.i_pixel_valid(pv), .i_pixel_bus(pbus), .o_pixel_rgb(rgb), .o_pixel_x(px),
		.o_pixel_y(py), .o_pixel_stb(stb), .o_frame_start(fs_pulse)
	);
	rgb_host_model u_host (
		.o_dot_clock(dot), .o_line_sync_n(hs_n), .o_frame_sync_n(vs_n),
		.o_pixel_valid(pv), .o_pixel_bus(pbus)
	);

	// Record every stored pixel and every frame start
	always @(posedge clk) begin
		if (stb === 1'b1) begin
			q_rgb.push_back(rgb);
			q_x.push_back(px);
			q_y.push_back(py);
		end
		if (fs_pulse === 1'b1)
			n_fs++;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Avalon access held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		byteen <= be;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 100)
			n_errors++;
	endtask

	// Colour widening by repeating the top bits
	function automatic logic [23:0] map(input logic [3:0] f, input logic p,
		input logic [23:0] w);
		if (f == FMT_16)
			return {w[20:16], w[20:18], w[13:8], w[13:12], w[4:0], w[4:2]};
		if (f == FMT_18 && !p)
			return {w[21:16], w[21:20], w[13:8], w[13:12], w[5:0], w[5:4]};
		if (f == FMT_18)
			return {w[17:12], w[17:16], w[11:6], w[11:10], w[5:0], w[5:4]};
		return w;
	endfunction

	task automatic chk_pix(input int i, input logic [23:0] r, input int x, input int y);
		cmp(q_rgb[i], r);
		cmp(q_x[i], x);
		cmp(q_y[i], y);
	endtask

	task automatic clr();
		q_rgb.delete();
		q_x.delete();
		q_y.delete();
		n_fs = 0;
	endtask

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// Reset values, low byte lanes only, unmapped offset
	task automatic t_reg();
		logic [31:0] d;
		for (int i = 0; i < NREG_RW; i++) begin
			bus(1'b0, RW_OFS[i], '0, 4'hF, d);
			cmp(d, RW_RST[i]);
			bus(1'b1, RW_OFS[i], '1, 4'h3, d);
			bus(1'b0, RW_OFS[i], '0, 4'hF, d);
			cmp(d, RW_MASK[i] & 32'h0000FFFF | RW_RST[i] & 32'hFFFF0000);
			bus(1'b1, RW_OFS[i], RW_RST[i], 4'hF, d);
		end
		bus(1'b0, 5'h1C, '0, 4'hF, d);
		cmp(d, 32'h00000000);
	endtask

	// Deselected port ignores writes and reads zero
	task automatic t_sel();
		logic [31:0] d;
		sel_n <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b1, OFS_PORCH, 32'h00001234, 4'hF, d);
		bus(1'b0, OFS_PORCH, '0, 4'hF, d);
		cmp(d, 32'h00000000);
		sel_n <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, OFS_PORCH, '0, 4'hF, d);
		cmp(d, RW_RST[REG_PORCH]);
	endtask

	// DE mode over every colour format, three lines per frame, two with pixels
	task automatic t_fmt();
		logic [31:0] d;
		logic [23:0] w;
		logic [3:0]  f [4] = '{FMT_24, FMT_18, FMT_18, FMT_16};
		bus(1'b1, OFS_PORCH, 32'h0000FFFF, 4'hF, d);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, OFS_CTRL, {23'h0, 1'b1, f[m], 2'h0, m == 2, 1'b0}, 4'hF, d);
			clr();
			u_host.send_line(1'b1, 3, 1'b1, 24'hA5C396);
			u_host.send_line(1'b1, 2, 1'b1, 24'h5A3C69);
			u_host.send_line(1'b0, 0, 1'b1, 24'h000000);
			cmp(q_rgb.size(), 5);
			cmp(n_fs, 1);
			for (int j = 0; j < 5; j++) begin
				w = (j < 3) ? 24'hA5C39A + j : 24'h5A3C6A + j;
				chk_pix(j, map(f[m], m == 2, w), (j < 3) ? j : j - 3, j / 3);
			end
		end
		// Status after four frames of three lines; then a line with capture off
		bus(1'b0, OFS_STATUS, '0, 4'hF, d);
		cmp(d, 32'h00040002);
		bus(1'b1, OFS_CTRL, {24'h0, FMT_24, 4'h0}, 4'hF, d);
		clr();
		u_host.send_line(1'b0, 3, 1'b1, 24'h123456);
		cmp(q_rgb.size(), 0);
	endtask

	// HV mode: porches locate column 0 and row 0, window keeps four columns; blanking lines short
	task automatic t_hv(input int hbp, input int vbp);
		logic [31:0] d;
		logic [23:0] b;
		bus(1'b1, OFS_PORCH, (vbp << 8) | hbp, 4'hF, d);
		bus(1'b1, OFS_WIN_X, 32'h00030000, 4'hF, d);
		bus(1'b1, OFS_CTRL, {23'h0, 1'b1, FMT_24, 4'h1}, 4'hF, d);
		clr();
		for (int l = 0; l <= vbp; l++)
			u_host.send_line(l < 2, (l < vbp) ? 4 : hbp + 482, 1'b0,
				24'(32'h300000 + (l << 12)));
		cmp(q_rgb.size(), 4);
		b = 24'(32'h300000 + (vbp << 12) + hbp + 1);
		for (int j = 0; j < 4; j++)
			chk_pix(j, b + 24'(j), j, 0);
		bus(1'b1, OFS_LB_ADDR, 32'h00000001, 4'hF, d);
		bus(1'b0, OFS_LB_DATA, '0, 4'hF, d);
		cmp(d, {8'h00, b + 24'h000001});
		bus(1'b1, OFS_WIN_X, RW_RST[REG_WIN_X], 4'hF, d);
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard well beyond the expected run
	initial begin
		#1600000;
		n_errors++;
		close_out();
	end

	// Main sequence, with a second reset in mid-run
	initial begin
		nrst = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = '0;
		wdata = '0;
		byteen = '0;
		sel_n = 1'b0;
		do_reset();
		t_reg();
		t_sel();
		t_fmt();
		t_hv(2, 2);
		t_hv(5, 17);
		do_reset();
		t_reg();
		close_out();
	end
endmodule
